//--- src/timer8_defs.svh
// register map, field positions, source codes and reset values of the 8-bit timer pair
`ifndef TIMER8_DEFS_SVH
`define TIMER8_DEFS_SVH

// ----------------------------------------------------------------------------
// register byte addresses within one timer instance
// ----------------------------------------------------------------------------
`define T8_CTRL_ADR        5'h00
`define T8_COUNT_ADR       5'h04
`define T8_SCALE_ADR       5'h08
`define T8_BOUND_ADR       5'h0C
`define T8_INST1_BASE      5'h10
`define T8_MAP_SIZE        8'h20

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define T8_CTRL_SRC_HI     7
`define T8_CTRL_SRC_LO     4
`define T8_CTRL_PIN_HI     3
`define T8_CTRL_PIN_LO     2
`define T8_CTRL_PWM_BIT    1
`define T8_CTRL_RES7_BIT   0

// ----------------------------------------------------------------------------
// scaling register fields
// ----------------------------------------------------------------------------
`define T8_SCALE_RED_BIT   7
`define T8_SCALE_PRE_HI    6
`define T8_SCALE_PRE_LO    5
`define T8_SCALE_DIV_HI    4
`define T8_SCALE_DIV_LO    0

// ----------------------------------------------------------------------------
// clock source codes in the control upper nibble
// ----------------------------------------------------------------------------
`define T8_SRC_OFF         4'h0
`define T8_SRC_SYS         4'h1
`define T8_SRC_HRC         4'h2
`define T8_SRC_LRC         4'h3
`define T8_SRC_SLRC        4'h4
`define T8_SRC_PIN0        4'h5
`define T8_SRC_PIN1        4'h6
`define T8_SRC_PIN2        4'h7
`define T8_SRC_CMP         4'h8

// ----------------------------------------------------------------------------
// reset values and wrap points
// ----------------------------------------------------------------------------
`define T8_REG_RST         8'h00
`define T8_TOP_8BIT        8'hFF
`define T8_TOP_7BIT        8'h7F
`define T8_TOP_6BIT        8'h3F

`endif

//--- src/timer8_pkg.sv
// types and shared decode functions of the 8-bit timer pair
`include "timer8_defs.svh"

package timer8_pkg;

  typedef logic [7:0] reg8_t;

  typedef enum logic [1:0] {
    MODE_PERIOD,
    MODE_PWM8,
    MODE_PWM7,
    MODE_PWM6
  } mode_e;

  // last prescaler count for ratio 1, 4, 16 or 64
  function automatic logic [5:0] prescale_last(input logic [1:0] sel);
    unique case (sel)
      2'h0: prescale_last = 6'h00;
      2'h1: prescale_last = 6'h03;
      2'h2: prescale_last = 6'h0F;
      2'h3: prescale_last = 6'h3F;
    endcase
  endfunction : prescale_last

  // operating mode from control and scaling bytes
  function automatic mode_e decode_mode(input reg8_t ctrl, input reg8_t scal);
    if (!ctrl[`T8_CTRL_PWM_BIT])
      decode_mode = MODE_PERIOD;
    else if (!scal[`T8_SCALE_RED_BIT])
      decode_mode = MODE_PWM8;
    else if (ctrl[`T8_CTRL_RES7_BIT])
      decode_mode = MODE_PWM7;
    else
      decode_mode = MODE_PWM6;
  endfunction : decode_mode

  // counter wrap point in the pwm modes
  function automatic reg8_t pwm_top(input mode_e mode);
    unique case (mode)
      MODE_PWM7: pwm_top = `T8_TOP_7BIT;
      MODE_PWM6: pwm_top = `T8_TOP_6BIT;
      default:   pwm_top = `T8_TOP_8BIT;
    endcase
  endfunction : pwm_top

endpackage : timer8_pkg

//--- src/timer8_scaler.sv
// prescaler and 5-bit scaler producing the scaled timer clock tick
`timescale 1ns/100ps

module timer8_scaler (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       src_tick_i,
  input  wire logic [1:0] pre_sel_i,
  input  wire logic [4:0] div_i,
  output logic            tick_o
);
  import timer8_pkg::*;

  logic [5:0] pre_cnt_r;
  logic [4:0] div_cnt_r;
  logic       pre_done;

  // prescaler wraps at 1, 4, 16 or 64 source edges [RULE_05]
  assign pre_done = src_tick_i && (pre_cnt_r >= prescale_last(pre_sel_i));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt_r <= 6'h00;
    end else if (src_tick_i) begin
      pre_cnt_r <= pre_done ? 6'h00 : pre_cnt_r + 6'h01;
    end
  end

  // scaler divides prescaled edges by field plus one [RULE_06]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_r <= 5'h00;
    end else if (pre_done) begin
      div_cnt_r <= (div_cnt_r >= div_i) ? 5'h00 : div_cnt_r + 5'h01;
    end
  end

  assign tick_o = pre_done && (div_cnt_r >= div_i);

endmodule : timer8_scaler

//--- src/timer8_period_pwm.sv
// two 8-bit up-counting timers with period and pwm modes behind a wishbone slave
//
// Summary of operation
// [RULE_01] control upper nibble picks the timer clock source among eight inputs
// [RULE_02] high rc source keeps clocking the timer while the emulator halts
// [RULE_03] control bits 3:2 pick one of three output pins per instance
// [RULE_04] selected pin is driven by the timer regardless of port direction
// [RULE_05] scaling bits 6:5 prescale the source by 1, 4, 16 or 64
// [RULE_06] scaling bits 4:0 further divide by field value plus one
// [RULE_07] counter counts up only, 8 bits, readable and writable by software
// [RULE_08] counter returns to zero when it reaches the upper bound
// [RULE_09] period mode gives a periodic wave and event, pwm mode a pwm wave
// [RULE_10] period mode output toggles on each bound match, 50 percent duty
// [RULE_11] control bit 1 set and scaling bit 7 clear selects 8-bit pwm
// [RULE_12] 8-bit pwm period is 256 ticks, high for bound plus one ticks
// [RULE_13] bound of 255 in 8-bit pwm keeps the output constantly high
// [RULE_14] pwm resolution is selectable between 6, 7 and 8 bits
// [RULE_15] with comparator gating built in, pwm output stops while comparator is 1
// [RULE_16] slow low rc source keeps the timer running and waking in sleep
// [RULE_17] second instance duplicates the first with its own registers and pins
// [RULE_18] 6-bit pwm period is 64 ticks, high for bound plus one ticks
// [RULE_19] software enables the slow low rc oscillator before relying on it
// [RULE_20] scaling bit 7 set in pwm mode reduces the counter modulus
// [RULE_21] a match flag pulses whenever the counter meets the upper bound
`timescale 1ns/100ps

`include "timer8_defs.svh"

module timer8_period_pwm #(
  parameter int  ADR_W   = 8,
  parameter bit  GATE_EN = 1'b0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone classic slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // clock sources, all synchronous levels
  input  wire logic             hrc_i,
  input  wire logic             lrc_i,
  input  wire logic             slow_lrc_i,
  input  wire logic [2:0]       src_pin_i,
  input  wire logic             cmp_i,
  // chip state
  input  wire logic             ice_halt_i,
  input  wire logic             sleep_i,
  // timer outputs: instance 0 on bits 2:0, instance 1 on bits 5:3
  output logic      [5:0]       tmr_pin_o,
  output logic      [5:0]       tmr_pin_oe_o,
  output logic      [1:0]       match_o,
  output logic                  wake_o
);
  import timer8_pkg::*;

  localparam int N_TMR = 2;

  // refuse an address bus too narrow for both register banks
  if (ADR_W < 6) begin : g_adr_w_check
    $error("timer8_period_pwm: ADR_W must be at least 6");
  end

  // --------------------------------------------------------------------------
  // register storage, one entry per instance
  // --------------------------------------------------------------------------
  reg8_t ctrl_r  [N_TMR];
  reg8_t scale_r [N_TMR];
  reg8_t bound_r [N_TMR];
  reg8_t cnt_r   [N_TMR];
  logic  wave_r  [N_TMR];

  logic [6:0]  src_prev_r;
  logic [6:0]  src_lvl;
  logic        ack_r;
  logic [31:0] rdata_r;

  logic        bus_req;
  logic        bus_wr;
  logic        wr_ok;
  logic        in_map;
  logic        inst_sel;
  logic [4:0]  reg_adr;

  logic        src_tick [N_TMR];
  logic        tmr_tick [N_TMR];
  logic        hit      [N_TMR];
  logic        wrap     [N_TMR];
  logic        wr_cnt   [N_TMR];
  mode_e       mode     [N_TMR];

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  // a request is taken in the cycle before ack rises
  assign bus_req  = wb_cyc_i && wb_stb_i && !ack_r;
  assign bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
  assign in_map   = (wb_adr_i < ADR_W'(`T8_MAP_SIZE));
  assign inst_sel = wb_adr_i[4];
  assign reg_adr  = {1'b0, wb_adr_i[3:0]};
  assign wr_ok    = bus_wr && in_map;

  // register selected by the current access
  // every input is an argument, so continuous callers see each change
  function automatic logic wr_hit(input logic ok, input logic sel, input logic inst,
                                  input logic [4:0] adr, input logic [4:0] target);
    wr_hit = ok && (sel == inst) && (adr == target);
  endfunction : wr_hit

  // --------------------------------------------------------------------------
  // source edge detection shared by both instances
  // --------------------------------------------------------------------------
  assign src_lvl = {cmp_i, src_pin_i, slow_lrc_i, lrc_i, hrc_i};

  // previous level of every source for rising-edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_prev_r <= 7'h00;
    end else begin
      src_prev_r <= src_lvl;
    end
  end

  // source edge of one instance, gated by halt and sleep
  // sources are levels sampled on clk_i, so each needs two clocks per period;
  // faster oscillators alias and lose edges
  function automatic logic pick_source(input logic [3:0] code, input logic [6:0] lvl,
                                       input logic [6:0] prev, input logic halt, input logic slp);
    logic [6:0] rise;
    logic       edge_sel;
    rise = lvl & ~prev;
    edge_sel = 1'b0;
    unique case (code)
      `T8_SRC_SYS:  edge_sel = 1'b1;
      `T8_SRC_HRC:  edge_sel = rise[0];
      `T8_SRC_LRC:  edge_sel = rise[1];
      `T8_SRC_SLRC: edge_sel = rise[2];
      `T8_SRC_PIN0: edge_sel = rise[3];
      `T8_SRC_PIN1: edge_sel = rise[4];
      `T8_SRC_PIN2: edge_sel = rise[5];
      `T8_SRC_CMP:  edge_sel = rise[6];
      default:      edge_sel = 1'b0;
    endcase
    // only the slow low rc survives sleep, only the high rc survives halt
    if (slp && (code != `T8_SRC_SLRC)) begin
      edge_sel = 1'b0;
    end
    if (halt && (code != `T8_SRC_HRC)) begin
      edge_sel = 1'b0;
    end
    pick_source = edge_sel;
  endfunction : pick_source

  // --------------------------------------------------------------------------
  // per-instance tick path and match decode
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < N_TMR; g++) begin : g_tmr
    // source select with emulator and sleep gating [RULE_01] [RULE_02] [RULE_16]
    assign src_tick[g] = pick_source(ctrl_r[g][`T8_CTRL_SRC_HI:`T8_CTRL_SRC_LO], src_lvl,
                                     src_prev_r, ice_halt_i, sleep_i);

    // identical divider chain per instance [RULE_17]
    timer8_scaler u_scaler (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .src_tick_i (src_tick[g]),
      .pre_sel_i  (scale_r[g][`T8_SCALE_PRE_HI:`T8_SCALE_PRE_LO]),
      .div_i      (scale_r[g][`T8_SCALE_DIV_HI:`T8_SCALE_DIV_LO]),
      .tick_o     (tmr_tick[g])
    );

    // mode from control bits 1 and 0 and scaling bit 7 [RULE_11] [RULE_14] [RULE_20]
    assign mode[g] = decode_mode(ctrl_r[g], scale_r[g]);

    // counter meets the bound on a scaled tick
    assign hit[g] = tmr_tick[g] && (cnt_r[g] == bound_r[g]);

    // period mode wraps at the bound, pwm modes at their modulus [RULE_08] [RULE_20]
    assign wrap[g] = (mode[g] == MODE_PERIOD) ? hit[g]
                                              : (tmr_tick[g] && (cnt_r[g] >= pwm_top(mode[g])));

    // software write strobe of this instance's counter
    assign wr_cnt[g] = wr_hit(wr_ok, inst_sel, 1'(g), reg_adr, `T8_COUNT_ADR);
  end

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  // control, scaling and bound writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N_TMR; i++) begin
        ctrl_r[i]  <= `T8_REG_RST;
        scale_r[i] <= `T8_REG_RST;
        bound_r[i] <= `T8_REG_RST;
      end
    end else begin
      for (int i = 0; i < N_TMR; i++) begin
        if (wr_hit(wr_ok, inst_sel, i[0], reg_adr, `T8_CTRL_ADR)) begin
          ctrl_r[i] <= wb_dat_i[7:0];
        end
        if (wr_hit(wr_ok, inst_sel, i[0], reg_adr, `T8_SCALE_ADR)) begin
          scale_r[i] <= wb_dat_i[7:0];
        end
        if (wr_hit(wr_ok, inst_sel, i[0], reg_adr, `T8_BOUND_ADR)) begin
          bound_r[i] <= wb_dat_i[7:0];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // up counter
  // --------------------------------------------------------------------------
  // software write wins over a tick in the same cycle
  // period mode wraps at the bound, pwm modes at their modulus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N_TMR; i++) begin
        cnt_r[i] <= `T8_REG_RST;
      end
    end else begin
      for (int i = 0; i < N_TMR; i++) begin
        if (wr_cnt[i]) begin
          cnt_r[i] <= wb_dat_i[7:0];                               // [RULE_07]
        end else if (wrap[i]) begin
          cnt_r[i] <= 8'h00;                                       // [RULE_08]
        end else if (tmr_tick[i]) begin
          cnt_r[i] <= cnt_r[i] + 8'h01;                            // [RULE_07]
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // waveform generation
  // --------------------------------------------------------------------------
  // period mode toggles per match; pwm high while count is within the bound
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N_TMR; i++) begin
        wave_r[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < N_TMR; i++) begin
        if (mode[i] == MODE_PERIOD) begin
          if (hit[i]) begin
            wave_r[i] <= !wave_r[i];                               // [RULE_09] [RULE_10]
          end
        end else if (GATE_EN && cmp_i) begin
          wave_r[i] <= 1'b0;                                       // [RULE_15]
        end else begin
          // high for bound plus one counts of the modulus [RULE_12] [RULE_13] [RULE_18]
          wave_r[i] <= (cnt_r[i] <= bound_r[i]);                   // [RULE_09]
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // pin steering
  // --------------------------------------------------------------------------
  // drive and enable only the selected pin of each instance
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_pin_o    <= 6'h00;
      tmr_pin_oe_o <= 6'h00;
    end else begin
      for (int i = 0; i < N_TMR; i++) begin
        for (int p = 0; p < 3; p++) begin
          // select code 1..3 forces pin p regardless of direction [RULE_03] [RULE_04]
          if (ctrl_r[i][`T8_CTRL_PIN_HI:`T8_CTRL_PIN_LO] == 2'(p + 1)) begin
            tmr_pin_o[i*3+p]    <= wave_r[i];
            tmr_pin_oe_o[i*3+p] <= 1'b1;
          end else begin
            tmr_pin_o[i*3+p]    <= 1'b0;
            tmr_pin_oe_o[i*3+p] <= 1'b0;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // match and wake events
  // --------------------------------------------------------------------------
  // one-cycle pulse per bound match in every mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_o <= 2'h0;
    end else begin
      for (int i = 0; i < N_TMR; i++) begin
        match_o[i] <= hit[i];                                      // [RULE_21] [RULE_09]
      end
    end
  end

  // wake while asleep on a slow low rc match of either instance
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= sleep_i && (hit[0] || hit[1]);                     // [RULE_16]
    end
  end

  // --------------------------------------------------------------------------
  // wishbone answer
  // --------------------------------------------------------------------------
  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
    end
  end

  // read data captured with the ack; unmapped addresses read zero
  // address bit 4 picks the instance, bits 3:0 the register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      rdata_r <= 32'h0000_0000;
      if (in_map) begin
        unique case (reg_adr)
          `T8_CTRL_ADR:  rdata_r[7:0] <= ctrl_r[inst_sel];
          `T8_COUNT_ADR: rdata_r[7:0] <= cnt_r[inst_sel];          // [RULE_07]
          `T8_SCALE_ADR: rdata_r[7:0] <= scale_r[inst_sel];
          `T8_BOUND_ADR: rdata_r[7:0] <= bound_r[inst_sel];
          default:       rdata_r[7:0] <= 8'h00;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

endmodule : timer8_period_pwm

//--- test/timer8_period_pwm_properties.sv
// concurrent checks on the ports of the timer pair
`timescale 1ns/100ps

module timer8_period_pwm_chk #(
  parameter int ADR_W = 8
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             hrc_i,
  input wire logic             lrc_i,
  input wire logic             slow_lrc_i,
  input wire logic [2:0]       src_pin_i,
  input wire logic             cmp_i,
  input wire logic             ice_halt_i,
  input wire logic             sleep_i,
  input wire logic [5:0]       tmr_pin_o,
  input wire logic [5:0]       tmr_pin_oe_o,
  input wire logic [1:0]       match_o,
  input wire logic             wake_o
);
  // ---------------------------------------------------------------
  // bus, pin and event relations
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without a request");
  AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bytes not zero");
  AST_DAT_HOLD: assert property ($changed(wb_dat_o) |-> wb_ack_o && !$past(wb_we_i))
    else $error("read data changed outside a read");
  AST_OE_ONEHOT: assert property ($onehot0(tmr_pin_oe_o[2:0]) && $onehot0(tmr_pin_oe_o[5:3]))
    else $error("more than one output pin per instance");
  AST_PIN_OWNED: assert property ((tmr_pin_o & ~tmr_pin_oe_o) == 6'h00)
    else $error("wave on an unselected pin");
  AST_RESET_CLEAR: assert property ($fell(rst_i) |-> tmr_pin_oe_o == 6'h00 && match_o == 2'h0)
    else $error("outputs not cleared by reset");
  AST_WAKE_SLEEP: assert property (wake_o |-> $past(sleep_i) || $past(sleep_i, 2))
    else $error("wake without sleep");
  AST_WAKE_MATCH: assert property (wake_o |-> (|match_o) || (|$past(match_o)))
    else $error("wake without a bound match");
endmodule : timer8_period_pwm_chk

//--- test/tb_timer8_period_pwm.sv
// self-checking bench of the timer pair against a register and timing model
`timescale 1ns/100ps

module tb_timer8_period_pwm;
  localparam int ADR_W = 8;
  logic        clk_i      = 1'b0;
  logic        rst_i      = 1'b1;
  logic        wb_cyc_i   = 1'b0;
  logic        wb_stb_i   = 1'b0;
  logic        wb_we_i    = 1'b0;
  logic [7:0]  wb_adr_i   = 8'h00;
  logic [3:0]  wb_sel_i   = 4'h0;
  logic [31:0] wb_dat_i   = 32'h0;
  logic        ice_halt_i = 1'b0;
  logic        sleep_i    = 1'b0;
  logic [6:0]  src_cnt    = 7'h00;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        hrc_i;
  logic        lrc_i;
  logic        slow_lrc_i;
  logic        cmp_i;
  logic [2:0]  src_pin_i;
  logic [5:0]  tmr_pin_o;
  logic [5:0]  gate_pin;
  logic [5:0]  tmr_pin_oe_o;
  logic [1:0]  match_o;
  logic        wake_o;
  logic [31:0] rd;
  logic [7:0]  d;
  logic [7:0]  mdl [8] = '{default: 8'h00};
  int          n_errors = 0;
  int          samples_checked = 0;
  int          n, k, e, top, hi, lo;

  // ---------------------------------------------------------------
  // clock, source edges and design
  // ---------------------------------------------------------------
  always #25 clk_i = ~clk_i;
  // each source code doubles the edge spacing of the one before
  always @(posedge clk_i) src_cnt <= src_cnt + 7'h01;
  assign {cmp_i, src_pin_i, slow_lrc_i, lrc_i, hrc_i} = src_cnt; // oscillators kept running
  timer8_period_pwm #(.ADR_W(ADR_W)) timer8_period_pwm_i (.*);
  // copy with comparator gating built in, sharing bus and sources
  timer8_period_pwm #(.ADR_W(ADR_W), .GATE_EN(1'b1)) timer8_period_pwm_gate_i (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o (), .wb_ack_o (), .hrc_i, .lrc_i, .slow_lrc_i, .src_pin_i, .cmp_i,
    .ice_halt_i, .sleep_i, .tmr_pin_o (gate_pin), .tmr_pin_oe_o (), .match_o (), .wake_o ()
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'h000000, v};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    wb(1'b1, a, v, 4'h1);
    if (a < 8'h20) mdl[a[4:2]] = v;
  endtask : wr

  task automatic rdck(input logic [7:0] a);
    wb(1'b0, a, 8'h00, 4'h0);
    check(rd, (a < 8'h20) ? {24'h000000, mdl[a[4:2]]} : 32'h0);
  endtask : rdck

  // stop, clear counter, then scaling, bound and control
  task automatic cfg(input logic [7:0] b, input logic [7:0] c, input logic [7:0] s, input logic [7:0] kb);
    wr(b, 8'h00);
    wr(b + 8'h04, 8'h00);
    wr(b + 8'h08, s);
    wr(b + 8'h0C, kb);
    wr(b, c);
  endtask : cfg

  task automatic run_until(input int b, input logic v, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_i);
      cnt++;
    end while (tmr_pin_o[b] !== v && cnt < 4000);
  endtask : run_until

  // high and low time of one full wave period
  task automatic meas(input int b);
    run_until(b, 1'b0, n);
    run_until(b, 1'b1, n);
    run_until(b, 1'b0, hi);
    run_until(b, 1'b1, lo);
  endtask : meas

  function automatic logic [2:0] pick(input int s);
    pick = (s % 4 == 0) ? 3'h0 : 3'(1 << (s % 4 - 1));
  endfunction : pick

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(62));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, random write and read back, ignored writes
    for (int a = 0; a < 8; a++) rdck(8'(a * 4));
    for (int a = 0; a < 8; a++) begin
      d = 8'($urandom());
      if (a % 4 == 0) d = d & 8'h0F;
      wr(8'(a * 4), d);
      rdck(8'(a * 4));
    end
    wb(1'b1, 8'h08, 8'h5A, 4'h0);
    rdck(8'h08);
    wr(8'h24, 8'h3C);
    rdck(8'h24);
    // output pin choice on both instances
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, 8'(s << 2));
      wr(8'h10, 8'(((s + 1) % 4) << 2));
      repeat (2) @(posedge clk_i);
      check(tmr_pin_oe_o, {pick(s + 1), pick(s)});
    end
    // every clock source in period mode
    for (int c = 1; c < 9; c++) begin
      cfg(8'h00, 8'((c << 4) | 4), 8'h00, 8'h01);
      meas(0);
      e = 2 << (c - 1);
      check(hi, e);
      check(lo, e);
    end
    // prescaler and scaler, alternating instances
    for (int p = 0; p < 4; p++) begin
      d = 8'($urandom_range(7));
      k = $urandom_range(3);
      cfg(8'(p % 2 * 16), 8'h14, 8'((p << 5) | d), 8'(k));
      meas(p % 2 * 3);
      e = (k + 1) * (1 << (2 * p)) * (d + 1);
      check(hi, e);
      check(lo, e);
    end
    // pwm at 8, 6 and 7 bit resolution
    for (int m = 0; m < 3; m++) begin
      top = (m == 0) ? 255 : (m == 1) ? 63 : 127;
      k = $urandom_range(top - 1);
      cfg(8'h00, (m == 2) ? 8'h17 : 8'h16, (m == 0) ? 8'h00 : 8'h80, 8'(k));
      meas(0);
      check(hi, k + 1);
      check(lo, top - k);
      // one match pulse per pwm period
      n = 0;
      repeat (2 * (top + 1)) begin
        @(posedge clk_i);
        if (match_o[0] === 1'b1) n++;
      end
      check(n, 2);
    end
    cfg(8'h00, 8'h16, 8'h00, 8'hFF);
    repeat (8) @(posedge clk_i);
    run_until(0, 1'b0, n);
    check(n, 4000);
    // gated copy is high only while the comparator is low, half of its period
    n = 0;
    repeat (256) begin
      @(posedge clk_i);
      if (gate_pin[0] === 1'b1) n++;
    end
    check(n, 128);
    // emulator halt: only the high rc source keeps counting
    ice_halt_i <= 1'b1;
    cfg(8'h00, 8'h24, 8'h00, 8'h01);
    meas(0);
    check(hi, 4);
    cfg(8'h00, 8'h14, 8'h00, 8'h01);
    repeat (20) @(posedge clk_i);
    rdck(8'h04);
    ice_halt_i <= 1'b0;
    // sleep: only the slow low rc source wakes the chip
    sleep_i <= 1'b1;
    cfg(8'h00, 8'h44, 8'h00, 8'h01);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wake_o !== 1'b1 && n < 200);
    check(n < 200, 1'b1);
    cfg(8'h00, 8'h14, 8'h00, 8'h01);
    n = 0;
    repeat (50) begin
      @(posedge clk_i);
      if (wake_o !== 1'b0) n++;
    end
    check(n, 0);
    sleep_i <= 1'b0;
    give_verdict();
  end

  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    give_verdict();
  end
endmodule : tb_timer8_period_pwm

bind timer8_period_pwm timer8_period_pwm_chk #(.ADR_W(ADR_W)) timer8_period_pwm_chk_i (.*);
